// [logic/uiu_defines.svh]
`ifndef UIU_DEFINES_SVH
`define UIU_DEFINES_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define UIU_OFS_OTG_CONTROL 8'h10
`define UIU_OFS_OTG_STATUS 8'h14
`define UIU_OFS_SERIAL_CTL 8'h18
`define UIU_OFS_LINE_FLAGS 8'h1C
`define UIU_OFS_STICKY 8'h20
`define UIU_OFS_PORT_MASKS 8'h24
`define UIU_OFS_FRAME_CNT 8'h28
`define UIU_OFS_LAST_PID 8'h2C
`define UIU_OFS_LAST_EP 8'h30
`define UIU_OFS_EP_MARK 8'h34
`define UIU_OFS_OTG_MASK 8'h38
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define UIU_OTG_EXT_VBUS_IND 7
`define UIU_OTG_DRV_VBUS_EXT 6
`define UIU_OTG_CHRG_VBUS 4
`define UIU_OTG_DISCHRG_VBUS 3
`define UIU_OTG_DM_PULLDOWN 2
`define UIU_OTG_DP_PULLDOWN 1
`define UIU_OTG_ID_PULLUP 0
`define UIU_SER_RX_DIFF 6
`define UIU_SER_RX_DM 5
`define UIU_SER_RX_DP 4
`define UIU_SER_TX_SE0 3
`define UIU_SER_TX_DATA 2
`define UIU_SER_TX_EN_N 1
`define UIU_SER_FSLS 0
`define UIU_FLG_TOKEN_OK 6
`define UIU_FLG_SE0 5
`define UIU_FLG_K 4
`define UIU_FLG_J 3
`define UIU_FLG_CRC16_ERR 2
`define UIU_FLG_RX_ACTIVE 1
`define UIU_FLG_RX_ERROR 0
`define UIU_EP_VALID_BIT 4
// ---------------------------------------------------------------
// reset values and constants
// ---------------------------------------------------------------
`define UIU_RST_OTG_CONTROL 8'h00
`define UIU_RST_SERIAL_CTL 4'h2
`define UIU_RST_FLAGS 7'h00
`define UIU_RST_OTG_MASK 32'h0000_0000
`define UIU_EP_MARK_OR 5'h10
`define UIU_LS_SE0 2'h0
`define UIU_LS_J 2'h1
`define UIU_LS_K 2'h2
`endif

// [logic/uiu_flag_bit.sv]
`include "uiu_defines.svh"
// one signal flag: set by hardware, cleared by packet start or software
module uiu_flag_bit (
  input wire logic core_clk, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic sticky, // sticky enable for this flag
  input wire logic pkt_start, // next packet has begun
  input wire logic follow, // flag tracks a level input
  input wire logic level, // level to follow
  input wire logic set_evt, // event setting the flag
  input wire logic sw_clr, // software writes one to clear
  output logic flag_q // flag value
);
  // -------------------------------------------------------------
  // flag update, set beats every clear
  // -------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else if (follow) begin
      if (level) begin
        flag_q <= 1'b1;
      end else if (!sticky || sw_clr) begin
        flag_q <= 1'b0;
      end
    end else if (set_evt) begin
      flag_q <= 1'b1;
    end else if (sw_clr || (pkt_start && !sticky)) begin
      flag_q <= 1'b0;
    end
  end
endmodule

// [logic/uiu_pkg.sv]
package uiu_pkg;
  typedef logic [31:0] uiu_word_t;
  typedef logic [6:0] uiu_flags_t;
  // token decode states
  typedef enum logic [2:0] {
    UIU_TK_IDLE = 3'b001,
    UIU_TK_SUM = 3'b010,
    UIU_TK_DONE = 3'b100
  } uiu_tok_state_e;
endpackage

// [logic/uiu_usb_interface_unit.sv]
`include "uiu_defines.svh"
module uiu_usb_interface_unit (
  input wire logic core_clk, // 20 MHz system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic reg_wr, // 32-bit write strobe
  input wire logic reg_rd, // 32-bit read strobe
  input wire logic [31:0] reg_wdata, // write data
  output logic [31:0] reg_rdata, // read data, one cycle after strobe
  output logic reg_rvalid, // read data valid pulse
  input wire logic [6:0] dev_addr, // enumerated device address
  input wire logic [7:0] rx_data, // phy receive byte
  input wire logic rx_valid, // phy receive byte valid
  input wire logic rx_active, // phy rx active
  input wire logic rx_error, // phy rx error
  input wire logic [1:0] line_state, // phy line state
  input wire logic b_valid, // phy b-session valid
  input wire logic id_gnd, // phy id ground
  input wire logic host_disc, // phy host disconnect
  input wire logic vbus_valid, // phy vbus valid
  input wire logic sess_valid, // phy session valid
  input wire logic sess_end, // phy session end
  input wire logic rx_rcv, // serial differential rx
  input wire logic rx_dm, // serial d-minus rx
  input wire logic rx_dp, // serial d-plus rx
  output logic external_vbus_indicator, // external vbus indicator mode
  output logic drive_vbus_external, // drive vbus externally
  output logic chrg_vbus, // phy charge vbus
  output logic dischrg_vbus, // phy discharge vbus
  output logic dm_pulldown, // phy dm pulldown
  output logic dp_pulldown, // phy dp pulldown
  output logic id_pullup, // phy id pullup enable
  output logic tx_se0, // serial tx se0
  output logic tx_dat, // serial tx data
  output logic tx_enable_n, // serial tx enable, active low
  output logic full_low_speed_serial_select, // serial interface mode
  output logic [3:0] flag_port, // masked flag outputs
  output logic [4:0] rx_ep_port // last endpoint, ORed with 0x10 when marked
);
  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] otg_control_reg;
  logic [3:0] serial_line_control_reg;
  logic [6:0] flag_sticky_enable_reg;
  logic [31:0] flag_port_masks_reg;
  logic [10:0] frame_counter_reg;
  logic [3:0] last_packet_id_reg;
  logic [4:0] last_endpoint_reg;
  logic [15:0] endpoint_mark_reg;
  logic [31:0] otg_flag_mask_reg;
  logic [6:0] line_error_flags;
  logic [6:0] flag_set;
  logic [6:0] flag_follow;
  logic [6:0] flag_level;
  logic [6:0] flag_clr;
  logic pkt_start;
  logic rx_active_reg;
  logic [1:0] line_state_reg;
  logic crc16_fail;
  logic token_ok;

  // decoding of a write strobe to one offset
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs, input logic w);
    wr_hit = w && (a == ofs);
  endfunction

  // ---------------------------------------------------------------
  // otg and serial control registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      otg_control_reg <= `UIU_RST_OTG_CONTROL;
    end else if (wr_hit(reg_addr, `UIU_OFS_OTG_CONTROL, reg_wr)) begin
      otg_control_reg <= {reg_wdata[7:6], 1'b0, reg_wdata[4:0]};
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      serial_line_control_reg <= `UIU_RST_SERIAL_CTL;
    end else if (wr_hit(reg_addr, `UIU_OFS_SERIAL_CTL, reg_wr)) begin
      serial_line_control_reg <= reg_wdata[3:0];
    end
  end

  // phy control pins are registered copies of the register bits, one cycle behind
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      external_vbus_indicator <= 1'b0;
      drive_vbus_external <= 1'b0;
      chrg_vbus <= 1'b0;
      dischrg_vbus <= 1'b0;
      dm_pulldown <= 1'b0;
      dp_pulldown <= 1'b0;
      id_pullup <= 1'b0;
      tx_se0 <= 1'b0;
      tx_dat <= 1'b0;
      tx_enable_n <= 1'b1;
      full_low_speed_serial_select <= 1'b0;
    end else begin
      external_vbus_indicator <= otg_control_reg[`UIU_OTG_EXT_VBUS_IND];
      drive_vbus_external <= otg_control_reg[`UIU_OTG_DRV_VBUS_EXT];
      chrg_vbus <= otg_control_reg[`UIU_OTG_CHRG_VBUS];
      dischrg_vbus <= otg_control_reg[`UIU_OTG_DISCHRG_VBUS];
      dm_pulldown <= otg_control_reg[`UIU_OTG_DM_PULLDOWN];
      dp_pulldown <= otg_control_reg[`UIU_OTG_DP_PULLDOWN];
      id_pullup <= otg_control_reg[`UIU_OTG_ID_PULLUP];
      tx_se0 <= serial_line_control_reg[`UIU_SER_TX_SE0];
      tx_dat <= serial_line_control_reg[`UIU_SER_TX_DATA];
      tx_enable_n <= serial_line_control_reg[`UIU_SER_TX_EN_N];
      full_low_speed_serial_select <= serial_line_control_reg[`UIU_SER_FSLS];
    end
  end

  // ---------------------------------------------------------------
  // mask, sticky, mark and otg mask storage
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_sticky_enable_reg <= `UIU_RST_FLAGS;
      flag_port_masks_reg <= 32'h0000_0000;
      endpoint_mark_reg <= 16'h0000;
      otg_flag_mask_reg <= `UIU_RST_OTG_MASK;
    end else begin
      if (wr_hit(reg_addr, `UIU_OFS_STICKY, reg_wr)) begin
        flag_sticky_enable_reg <= reg_wdata[6:0];
      end
      if (wr_hit(reg_addr, `UIU_OFS_PORT_MASKS, reg_wr)) begin
        flag_port_masks_reg <= reg_wdata;
      end
      if (wr_hit(reg_addr, `UIU_OFS_EP_MARK, reg_wr)) begin
        endpoint_mark_reg <= reg_wdata[15:0];
      end
      if (wr_hit(reg_addr, `UIU_OFS_OTG_MASK, reg_wr)) begin
        otg_flag_mask_reg <= reg_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // token decode: pid, address, endpoint, crc5
  // ---------------------------------------------------------------
  uiu_pkg::uiu_tok_state_e tok_state_reg;
  logic [1:0] byte_idx_reg;
  logic [7:0] pid_byte_reg;
  logic [7:0] tok_b1_reg;
  logic [15:0] crc16_reg;
  logic is_token;
  logic is_data;
  logic is_sof;
  logic [4:0] crc5_calc;
  logic [10:0] tok_field;
  logic [4:0] tok_crc;

  // crc5 of an 11-bit token field, lsb first, returned in the wire order of the crc field
  function automatic logic [4:0] crc5(input logic [10:0] d);
    logic [4:0] c;
    logic fb;
    c = 5'h1F;
    for (int i = 0; i < 11; i++) begin
      fb = d[i] ^ c[4];
      c = {c[3:0], 1'b0} ^ (fb ? 5'h05 : 5'h00);
    end
    for (int i = 0; i < 5; i++) crc5[i] = ~c[4 - i];
  endfunction

  // crc16 update for one byte, lsb first
  function automatic logic [15:0] crc16_step(input logic [15:0] cin, input logic [7:0] d);
    logic [15:0] c;
    logic fb;
    c = cin;
    for (int i = 0; i < 8; i++) begin
      fb = d[i] ^ c[15];
      c = {c[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
    end
    crc16_step = c;
  endfunction

  assign pkt_start = rx_active && !rx_active_reg;
  assign is_token = (pid_byte_reg[1:0] == 2'h1);
  assign is_data = (pid_byte_reg[1:0] == 2'h3);
  assign is_sof = (pid_byte_reg[3:0] == 4'h5);
  assign tok_field = {rx_data[2:0], tok_b1_reg};
  assign tok_crc = rx_data[7:3];
  assign crc5_calc = crc5(tok_field);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tok_state_reg <= uiu_pkg::UIU_TK_IDLE;
      byte_idx_reg <= 2'h0;
      pid_byte_reg <= 8'h00;
      tok_b1_reg <= 8'h00;
      crc16_reg <= 16'hFFFF;
      rx_active_reg <= 1'b0;
    end else begin
      rx_active_reg <= rx_active;
      case (tok_state_reg)
        uiu_pkg::UIU_TK_IDLE: begin
          byte_idx_reg <= 2'h0;
          crc16_reg <= 16'hFFFF;
          pid_byte_reg <= 8'h00; // an empty packet must not reuse the last pid
          if (pkt_start) begin
            tok_state_reg <= uiu_pkg::UIU_TK_SUM;
          end
        end
        uiu_pkg::UIU_TK_SUM: begin
          if (rx_valid) begin
            if (byte_idx_reg == 2'h0) begin
              pid_byte_reg <= rx_data;
            end else begin
              crc16_reg <= crc16_step(crc16_reg, rx_data);
            end
            if (byte_idx_reg == 2'h1) begin
              tok_b1_reg <= rx_data;
            end
            if (byte_idx_reg != 2'h3) begin
              byte_idx_reg <= byte_idx_reg + 2'h1;
            end
          end
          if (!rx_active) begin
            tok_state_reg <= uiu_pkg::UIU_TK_DONE;
          end
        end
        uiu_pkg::UIU_TK_DONE: begin
          tok_state_reg <= uiu_pkg::UIU_TK_IDLE;
        end
        default: begin
          tok_state_reg <= uiu_pkg::UIU_TK_IDLE;
        end
      endcase
    end
  end

  // third token byte: crc5 and pid good, address matched except on sof
  assign token_ok = (tok_state_reg == uiu_pkg::UIU_TK_SUM) && rx_valid
    && (byte_idx_reg == 2'h2) && is_token
    && (pid_byte_reg[3:0] == ~pid_byte_reg[7:4])
    && (crc5_calc == tok_crc)
    && (is_sof || (tok_b1_reg[6:0] == dev_addr));
  // crc16 residual check at end of a data packet
  assign crc16_fail = (tok_state_reg == uiu_pkg::UIU_TK_DONE) && is_data
    && (crc16_reg != 16'h800D);

  // ---------------------------------------------------------------
  // pid, endpoint and frame capture
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_packet_id_reg <= 4'h0;
      last_endpoint_reg <= 5'h00;
      frame_counter_reg <= 11'h000;
    end else begin
      if ((tok_state_reg == uiu_pkg::UIU_TK_SUM) && rx_valid && (byte_idx_reg == 2'h0)) begin
        last_packet_id_reg <= rx_data[3:0];
      end
      if (wr_hit(reg_addr, `UIU_OFS_FRAME_CNT, reg_wr)) begin
        frame_counter_reg <= reg_wdata[10:0];
      end else if (token_ok && is_sof) begin
        frame_counter_reg <= tok_field;
      end
      if (token_ok && !is_sof) begin
        last_endpoint_reg <= {1'b1, tok_field[10:7]};
      end
    end
  end

  // ---------------------------------------------------------------
  // signal flags
  // ---------------------------------------------------------------
  always_comb begin
    flag_set = 7'h00;
    flag_set[`UIU_FLG_TOKEN_OK] = token_ok;
    flag_set[`UIU_FLG_SE0] = (line_state == `UIU_LS_SE0);
    flag_set[`UIU_FLG_K] = (line_state == `UIU_LS_K);
    flag_set[`UIU_FLG_J] = (line_state == `UIU_LS_J);
    flag_set[`UIU_FLG_CRC16_ERR] = crc16_fail;
    flag_follow = 7'h03;
    flag_level = {5'h00, rx_active, rx_error};
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_state_reg <= 2'h1;
    end else begin
      line_state_reg <= line_state;
    end
  end

  assign flag_clr = wr_hit(reg_addr, `UIU_OFS_LINE_FLAGS, reg_wr) ? reg_wdata[6:0] : 7'h00;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_flag
      uiu_flag_bit u_flag (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .sticky(flag_sticky_enable_reg[gi]),
        .pkt_start(pkt_start),
        .follow(flag_follow[gi]),
        .level(flag_level[gi]),
        .set_evt(flag_set[gi] && !(gi == `UIU_FLG_SE0 || gi == `UIU_FLG_K
          || gi == `UIU_FLG_J) || (flag_set[gi] && line_state_reg != line_state)
          || (flag_set[gi] && pkt_start)),
        .sw_clr(flag_clr[gi]),
        .flag_q(line_error_flags[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // port outputs and marked endpoint
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_port <= 4'h0;
      rx_ep_port <= 5'h00;
    end else begin
      for (int p = 0; p < 4; p++) begin
        flag_port[p] <= |(flag_port_masks_reg[p*8 +: 7] & line_error_flags);
      end
      if (last_endpoint_reg[4] && endpoint_mark_reg[last_endpoint_reg[3:0]]) begin
        rx_ep_port <= {1'b0, last_endpoint_reg[3:0]} | `UIU_EP_MARK_OR;
      end else begin
        rx_ep_port <= {1'b0, last_endpoint_reg[3:0]};
      end
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      case (reg_addr)
        `UIU_OFS_OTG_CONTROL: reg_rdata <= {24'h0, otg_control_reg};
        `UIU_OFS_OTG_STATUS: reg_rdata <= {26'h0, b_valid, id_gnd, host_disc,
          vbus_valid, sess_valid, sess_end};
        `UIU_OFS_SERIAL_CTL: reg_rdata <= {25'h0, rx_rcv, rx_dm, rx_dp,
          serial_line_control_reg};
        `UIU_OFS_LINE_FLAGS: reg_rdata <= {25'h0, line_error_flags};
        `UIU_OFS_STICKY: reg_rdata <= {25'h0, flag_sticky_enable_reg};
        `UIU_OFS_PORT_MASKS: reg_rdata <= flag_port_masks_reg;
        `UIU_OFS_FRAME_CNT: reg_rdata <= {21'h0, frame_counter_reg};
        `UIU_OFS_LAST_PID: reg_rdata <= {28'h0, last_packet_id_reg};
        `UIU_OFS_LAST_EP: reg_rdata <= {27'h0, last_endpoint_reg};
        `UIU_OFS_EP_MARK: reg_rdata <= {16'h0, endpoint_mark_reg};
        `UIU_OFS_OTG_MASK: reg_rdata <= otg_flag_mask_reg;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// [tb/test_usb_phy_interface_regs.sv]
module test_usb_phy_interface_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  uiu_pkg::uiu_word_t reg_wdata = 32'h0;
  uiu_pkg::uiu_word_t reg_rdata;
  uiu_pkg::uiu_word_t rd_val;
  logic reg_rvalid;
  logic [6:0] dev_addr = 7'h00;
  logic [7:0] rx_data;
  logic rx_valid, rx_active, rx_error;
  logic [1:0] line_state;
  logic [5:0] otg_st = 6'h00;
  logic [2:0] ser_rx = 3'h0;
  logic [6:0] otg_out;
  logic [3:0] ser_out;
  logic [3:0] flag_port;
  logic [4:0] rx_ep_port;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  uiu_usb_interface_unit DUT (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .dev_addr(dev_addr), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_active(rx_active), .rx_error(rx_error), .line_state(line_state),
    .b_valid(otg_st[5]), .id_gnd(otg_st[4]), .host_disc(otg_st[3]), .vbus_valid(otg_st[2]),
    .sess_valid(otg_st[1]), .sess_end(otg_st[0]), .rx_rcv(ser_rx[2]), .rx_dm(ser_rx[1]),
    .rx_dp(ser_rx[0]), .external_vbus_indicator(otg_out[6]),
    .drive_vbus_external(otg_out[5]), .chrg_vbus(otg_out[4]), .dischrg_vbus(otg_out[3]),
    .dm_pulldown(otg_out[2]), .dp_pulldown(otg_out[1]), .id_pullup(otg_out[0]),
    .tx_se0(ser_out[3]), .tx_dat(ser_out[2]), .tx_enable_n(ser_out[1]),
    .full_low_speed_serial_select(ser_out[0]), .flag_port(flag_port), .rx_ep_port(rx_ep_port));
  uiu_phy_model phy (.core_clk(core_clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_active(rx_active), .rx_error(rx_error), .line_state(line_state));
  // ---------------------------------------------------------------
  // clock, timeout and verdict
  // ---------------------------------------------------------------
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // compare and register access tasks
  // ---------------------------------------------------------------
  task automatic chk_word(input string n, input uiu_pkg::uiu_word_t e, g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic [6:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input uiu_pkg::uiu_word_t d);
    @(posedge core_clk) #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk) #1 reg_wr = 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input uiu_pkg::uiu_word_t m, e, input string n);
    @(posedge core_clk) #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk) #1 reg_rd = 1'b0;
    rd_val = reg_rdata;
    chk_pin("read valid", 7'h01, {6'h00, reg_rvalid});
    chk_word(n, e, rd_val & m);
  endtask
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] ofs [11] = '{8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30,
      8'h34, 8'h38, 8'h00};
    logic [1:0] ls [3] = '{2'h0, 2'h2, 2'h1};
    uiu_pkg::uiu_word_t acc = 32'h0;
    repeat (8) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    chk_pin("tx enable", 7'h01, {6'h00, ser_out[1]});
    foreach (ofs[i]) rchk(ofs[i], '1, (ofs[i] == 8'h18) ? 32'h2 : 32'h0, "reset value");
    // otg control drives its pins
    wr(8'h10, 32'hFFFF_FFFF);
    settle();
    chk_pin("otg pins", 7'h7F, otg_out);
    rchk(8'h10, '1, 32'hDF, "otg control");
    wr(8'h10, 32'h55);
    settle();
    chk_pin("otg pins", 7'h35, otg_out);
    // live status lines, one at a time
    for (int i = 0; i < 6; i++) begin
      otg_st = 6'h01 << i;
      rchk(8'h14, '1, 32'h1 << i, "otg status");
    end
    // serial interface
    ser_rx = 3'h5;
    wr(8'h18, 32'hFFFF_FFFF);
    settle();
    chk_pin("serial pins", 7'h0F, {3'h0, ser_out});
    rchk(8'h18, '1, 32'h5F, "serial control");
    wr(8'h18, 32'h0);
    settle();
    chk_pin("serial pins", 7'h00, {3'h0, ser_out});
    // storage and read-only places
    wr(8'h28, 32'hFFFF_FFFF);
    rchk(8'h28, '1, 32'h7FF, "frame counter");
    wr(8'h38, 32'hA5A5_5A5A);
    rchk(8'h38, '1, 32'hA5A5_5A5A, "otg flag mask");
    wr(8'h2C, 32'hF);
    rchk(8'h2C, '1, 32'h0, "pid read only");
    wr(8'h34, 32'hFFFF_1234);
    rchk(8'h34, '1, 32'h1234, "endpoint mark");
    // token to our address, endpoint 0
    phy.send(8'h2D, 8'h00, 8'h10);
    rchk(8'h1C, 32'h44, 32'h40, "token flag");
    rchk(8'h2C, '1, 32'hD, "last pid");
    rchk(8'h30, '1, 32'h10, "last endpoint");
    chk_pin("ep port", 7'h00, {2'h0, rx_ep_port});
    wr(8'h34, 32'h1);
    settle();
    chk_pin("ep port", 7'h10, {2'h0, rx_ep_port});
    dev_addr = 7'h05;
    phy.send(8'h2D, 8'h00, 8'h10);
    rchk(8'h1C, 32'h40, 32'h0, "foreign token");
    phy.send(8'hA5, 8'h00, 8'h10);
    rchk(8'h28, '1, 32'h0, "sof frame");
    // data packets with bad then good check sums
    phy.send(8'hC3, 8'h12, 8'h34);
    rchk(8'h1C, 32'h4, 32'h4, "crc16 flag");
    phy.send(8'hC3, 8'h00, 8'h00);
    rchk(8'h1C, 32'h4, 32'h0, "crc16 flag");
    wr(8'h20, 32'h4);
    phy.send(8'hC3, 8'h12, 8'h34);
    phy.send(8'hC3, 8'h00, 8'h00);
    rchk(8'h1C, 32'h4, 32'h4, "sticky crc16");
    wr(8'h1C, 32'h4);
    rchk(8'h1C, 32'h4, 32'h0, "cleared crc16");
    // level-following flags
    phy.levels(1'b1, 1'b1);
    rchk(8'h1C, 32'h3, 32'h3, "rx follow");
    phy.levels(1'b0, 1'b0);
    rchk(8'h1C, 32'h3, 32'h0, "rx follow");
    // sticky line flags onto the port outputs
    wr(8'h20, 32'h7F);
    wr(8'h1C, 32'h7F);
    wr(8'h24, 32'h1000_1001);
    settle();
    chk_pin("flag ports", 7'h00, {3'h0, flag_port});
    foreach (ls[i]) begin
      phy.set_line(ls[i]);
      acc = acc | (32'h20 >> i);
      rchk(8'h1C, 32'h38, acc, "line flags");
    end
    settle();
    chk_pin("flag ports", 7'h0A, {3'h0, flag_port});
    phy.levels(1'b0, 1'b1);
    settle();
    chk_pin("flag ports", 7'h0B, {3'h0, flag_port});
    report_and_stop();
  end
endmodule

// [tb/uiu_iface_checker.sv]
// ---------------------------------------------------------------
// port checker for the interface unit
// ---------------------------------------------------------------
module uiu_iface_checker (
  input wire logic core_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic [7:0] reg_addr, // address
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [31:0] reg_wdata, // write data
  input wire logic [31:0] reg_rdata, // read data
  input wire logic reg_rvalid, // read valid
  input wire logic external_vbus_indicator, // otg bit 7
  input wire logic drive_vbus_external, // otg bit 6
  input wire logic chrg_vbus, // otg bit 4
  input wire logic dischrg_vbus, // otg bit 3
  input wire logic dm_pulldown, // otg bit 2
  input wire logic dp_pulldown, // otg bit 1
  input wire logic id_pullup, // otg bit 0
  input wire logic tx_se0, // serial bit 3
  input wire logic tx_dat, // serial bit 2
  input wire logic tx_enable_n, // serial bit 1
  input wire logic full_low_speed_serial_select // serial bit 0
);
  logic otg_wr;
  logic ser_wr;
  // write decodes for the two control registers
  assign otg_wr = reg_wr && reg_addr == 8'h10;
  assign ser_wr = reg_wr && reg_addr == 8'h18;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe got no valid pulse");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("valid pulse without read strobe");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_vbus_mode_ctl: assert property (otg_wr |-> ##2
    {external_vbus_indicator, drive_vbus_external} == $past(reg_wdata[7:6], 2))
    else $error("vbus mode outputs wrong");
  a_vbus_charge_ctl: assert property (otg_wr |-> ##2
    {chrg_vbus, dischrg_vbus} == $past(reg_wdata[4:3], 2))
    else $error("vbus charge outputs wrong");
  a_pulldown_ctl: assert property (otg_wr |-> ##2
    {dm_pulldown, dp_pulldown} == $past(reg_wdata[2:1], 2))
    else $error("pulldown outputs wrong");
  a_id_pullup_ctl: assert property (otg_wr |-> ##2 id_pullup == $past(reg_wdata[0], 2))
    else $error("id pullup output wrong");
  a_serial_tx_ctl: assert property (ser_wr |-> ##2
    {tx_se0, tx_dat} == $past(reg_wdata[3:2], 2))
    else $error("serial tx outputs wrong");
  a_tx_enable_ctl: assert property (ser_wr |-> ##2 tx_enable_n == $past(reg_wdata[1], 2))
    else $error("tx enable output wrong");
  a_tx_off_reset: assert property ($fell(sys_rst) |-> tx_enable_n)
    else $error("tx enable not off after reset");
  a_fsls_mode_ctl: assert property (ser_wr |-> ##2
    full_low_speed_serial_select == $past(reg_wdata[0], 2))
    else $error("serial mode output wrong");
endmodule
bind uiu_usb_interface_unit uiu_iface_checker chk (.core_clk, .sys_rst, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .external_vbus_indicator, .drive_vbus_external,
  .chrg_vbus, .dischrg_vbus, .dm_pulldown, .dp_pulldown, .id_pullup, .tx_se0, .tx_dat,
  .tx_enable_n, .full_low_speed_serial_select);

// [tb/uiu_phy_model.sv]
// ---------------------------------------------------------------
// receive side of the transceiver
// ---------------------------------------------------------------
module uiu_phy_model (
  input wire logic core_clk, // clock
  output logic [7:0] rx_data, // received byte
  output logic rx_valid, // byte valid
  output logic rx_active, // packet in progress
  output logic rx_error, // receive error
  output logic [1:0] line_state // line state
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus, line at J
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_active = 1'b0;
    rx_error = 1'b0;
    line_state = 2'h1;
  end
  // one three-byte packet, a byte per cycle
  task automatic send(input logic [7:0] b0, b1, b2);
    logic [7:0] pk [3];
    pk = '{b0, b1, b2};
    @(posedge core_clk) #1 rx_active = 1'b1;
    foreach (pk[i]) begin
      @(posedge core_clk) #1 rx_valid = 1'b1;
      rx_data = pk[i];
    end
    @(posedge core_clk) #1 rx_valid = 1'b0;
    rx_data = ~rx_data; // released byte lane stops showing old data
    rx_active = 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  // hold activity and error levels
  task automatic levels(input logic act, err);
    @(posedge core_clk) #1 rx_active = act;
    rx_error = err;
  endtask
  // move the line state
  task automatic set_line(input logic [1:0] ls);
    @(posedge core_clk) #1 line_state = ls;
  endtask
endmodule
